// [rtl/reference_input_selector.sv]
// Reference input selector: register port, input loss tracking and selection.
// Assumes input clocks are sampled on i_clock, which is far faster than them.
`timescale 1ns/10ps

// Overview of operation
// - Every input has a two-bit priority where 00 is the lowest and 11 the highest.
// - Among inputs with equal priority the lowest-numbered input wins.
// - A prescale bit makes the validation count run on the input clock divided by 1 or by 4.
// - The revertive setting only matters when the low mode bit is 1.
// - With revertive off, a non-selected input becoming valid leaves the selection alone.
// - With revertive on, a revalidated input takes over only if it outranks the current reference.
// - After reset revertive switching is off and the mode is manual.
// - Mode codes are 00 manual, 01 automatic, 10 short-term holdover, 11 automatic with holdover.
// - In mode 00 the reference is the manually chosen input; in mode 10 it is that input until failover.
// - In automatic modes a state machine picks the reference from loss states and priorities.
// - The manual choice routes input 0 for 00 and input 1 for 01 and is ignored in automatic modes.
// - In short-term holdover a hold-off counter starts on loss, fails over at zero, then reloads.
// - A failed input counts valid periods down, missing edges reload it, and completion clears loss once its loss input is low.
module reference_input_selector
  import ref_select_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  // Clock, reset and freeze.
  input  wire logic         i_clock,
  input  wire logic         i_reset_n,
  input  wire logic         i_enable,
  // Register port.
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic         i_reg_write,
  input  wire logic [7:0]   i_reg_wdata,
  output logic [7:0]        o_reg_rdata,
  // Reference inputs and status.
  input  wire logic [N-1:0] i_ref_clock,
  input  wire logic [N-1:0] i_ref_loss,
  output logic [1:0]        o_ref_select,
  output logic              o_ref_valid,
  output logic [N-1:0]      o_loss_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  priority_s  prio_q, prio_d;
  mode_s      mode_q, mode_d;
  logic [7:0] holdoff_q, holdoff_d;
  counter_s   cnt_q, cnt_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    prio_d    = prio_q;
    mode_d    = mode_q;
    holdoff_d = holdoff_q;
    cnt_d     = cnt_q;
    if (i_reg_write) begin
      case (i_reg_addr)
        ADDR_PRIORITY: prio_d    = i_reg_wdata;
        ADDR_MODE:     mode_d    = i_reg_wdata & MASK_MODE;
        ADDR_HOLDOFF:  holdoff_d = i_reg_wdata;
        ADDR_COUNTER:  cnt_d     = i_reg_wdata & MASK_COUNTER;
        default:       ;
      endcase
    end
    case (i_reg_addr)
      ADDR_PRIORITY: rdata_d = prio_q;
      ADDR_MODE:     rdata_d = mode_q;
      ADDR_HOLDOFF:  rdata_d = holdoff_q;
      ADDR_COUNTER:  rdata_d = cnt_q;
      default:       rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prio_q    <= RESET_PRIORITY;
      mode_q    <= RESET_MODE;
      holdoff_q <= RESET_HOLDOFF;
      cnt_q     <= RESET_COUNTER;
      rdata_q   <= 8'h00;
    end else if (i_enable) begin
      prio_q    <= prio_d;
      mode_q    <= mode_d;
      holdoff_q <= holdoff_d;
      cnt_q     <= cnt_d;
      rdata_q   <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.
  logic [N-1:0] clk_s1_q, clk_s2_q, clk_s3_q;
  logic [N-1:0] los_s1_q, los_s2_q;
  logic [N-1:0] edge_w;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_s1_q <= '0;
      clk_s2_q <= '0;
      clk_s3_q <= '0;
      los_s1_q <= '0;
      los_s2_q <= '0;
    end else if (i_enable) begin
      clk_s1_q <= i_ref_clock;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      los_s1_q <= i_ref_loss;
      los_s2_q <= los_s1_q;
    end
  end

  assign edge_w = clk_s2_q & ~clk_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Validation counters, one per input.
  // The missing-edge window is a parameter because the input period is unknown here.
  localparam int          WIN_W   = 8;
  localparam logic [7:0]  WIN_MAX = 8'hFF;

  logic [N-1:0]       loss_q, loss_d;
  logic [8:0]         val_q [N], val_d [N];
  logic [WIN_W-1:0]   win_q [N], win_d [N];
  logic [1:0]         pre_q [N], pre_d [N];
  logic [N-1:0]       revalid_w;
  logic [8:0]         val_len;

  always_comb begin
    val_len = mode_q.validation_prescale_sel ? VAL_LEN_DIV4[cnt_q.validation_count]
                                             : VAL_LEN_DIV1[cnt_q.validation_count];
    loss_d    = loss_q;
    revalid_w = '0;
    for (int i = 0; i < N; i++) begin
      val_d[i] = val_q[i];
      win_d[i] = win_q[i];
      pre_d[i] = pre_q[i];
      if (los_s2_q[i] && !loss_q[i]) begin
        loss_d[i] = 1'b1;
        val_d[i]  = val_len;
        win_d[i]  = '0;
        pre_d[i]  = '0;
      end else if (loss_q[i]) begin
        if (edge_w[i]) begin
          win_d[i] = '0;
          pre_d[i] = pre_q[i] + 2'h1;
          if (!mode_q.validation_prescale_sel || pre_q[i] == 2'h3) begin
            if (val_q[i] <= 9'h001) begin
              loss_d[i]    = los_s2_q[i];
              revalid_w[i] = !los_s2_q[i];
            end else begin
              val_d[i] = val_q[i] - 9'h001;
            end
          end
        end else if (win_q[i] == WIN_MAX) begin
          val_d[i] = val_len;
          win_d[i] = '0;
        end else begin
          win_d[i] = win_q[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loss_q <= '0;
      for (int i = 0; i < N; i++) begin
        val_q[i] <= '0;
        win_q[i] <= '0;
        pre_q[i] <= '0;
      end
    end else if (i_enable) begin
      loss_q <= loss_d;
      for (int i = 0; i < N; i++) begin
        val_q[i] <= val_d[i];
        win_q[i] <= win_d[i];
        pre_q[i] <= pre_d[i];
      end
    end
  end

  assign o_loss_flag = loss_q;

  ////////////////////////////////////////////////////////////////////////////
  // Priority pick and selection state machine.
  logic [1:0] prio_w [N];
  logic [1:0] best_w;
  logic       any_w;

  assign prio_w[0] = prio_q.prio_0;
  assign prio_w[1] = prio_q.prio_1;
  assign prio_w[2] = prio_q.prio_2;
  assign prio_w[3] = prio_q.prio_3;

  always_comb begin
    best_w = '0;
    any_w  = 1'b0;
    // Scan from the top so that a non-strict compare keeps the lowest index on ties.
    // Next-cycle loss flags let an input that revalidates now take part at once.
    for (int i = N - 1; i >= 0; i--) begin
      if (!loss_d[i] && (!any_w || prio_w[i] >= prio_w[best_w])) begin
        best_w = 2'(i);
        any_w  = 1'b1;
      end
    end
  end

  sel_state_e  state_q, state_d;
  logic [1:0]  auto_q, auto_d;
  logic [7:0]  hold_q, hold_d;
  logic [HOLD_PRE_W-1:0] hpre_q, hpre_d;
  logic        manual_w, hold_tick_w;
  logic        fover_q, fover_d;
  logic        rev_up_w;

  assign manual_w    = !mode_q.ref_select_mode[0];
  assign hold_tick_w = hpre_q == HOLD_PRE_W'((1 << HOLD_EXP[cnt_q.holdoff_prescale]) - 1);

  always_comb begin
    state_d = state_q;
    auto_d  = auto_q;
    hold_d  = hold_q;
    hpre_d  = hpre_q;
    fover_d = fover_q;
    rev_up_w = 1'b0;
    // Revertive switching only counts an input that outranks the current reference.
    for (int i = 0; i < N; i++) begin
      if (revalid_w[i] && prio_w[i] > prio_w[auto_q]) begin
        rev_up_w = 1'b1;
      end
    end
    // The failover of short-term holdover lasts only while the manual input stays lost.
    if (mode_q.ref_select_mode != MODE_SHORT_HOLD || !loss_q[mode_q.manual_sel]) begin
      fover_d = 1'b0;
    end
    case (state_q)
      SEL_IDLE: begin
        auto_d  = mode_q.manual_sel;
        state_d = SEL_LOCKED;
      end
      SEL_LOCKED: begin
        if (mode_q.ref_select_mode == MODE_SHORT_HOLD && loss_q[mode_q.manual_sel] && !fover_q) begin
          hold_d  = holdoff_q;
          hpre_d  = '0;
          state_d = SEL_HOLDOFF;
        end else if (!manual_w) begin
          if (loss_q[auto_q]) begin
            auto_d  = best_w;
            state_d = any_w ? SEL_LOCKED : SEL_NONE;
          end else if (mode_q.revertive_enable && rev_up_w) begin
            auto_d = best_w;
          end
        end
      end
      SEL_HOLDOFF: begin
        if (mode_q.ref_select_mode != MODE_SHORT_HOLD) begin
          state_d = SEL_LOCKED;
        end else if (hold_tick_w) begin
          hpre_d = '0;
          if (hold_q == 8'h00) begin
            auto_d  = best_w;
            fover_d = 1'b1;
            hold_d  = holdoff_q;
            state_d = any_w ? SEL_LOCKED : SEL_NONE;
          end else begin
            hold_d = hold_q - 8'h01;
          end
        end else begin
          hpre_d = hpre_q + 1'b1;
        end
      end
      SEL_NONE: begin
        if (any_w || manual_w) begin
          auto_d  = best_w;
          state_d = SEL_LOCKED;
        end
      end
      default: state_d = SEL_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= SEL_IDLE;
      auto_q  <= '0;
      hold_q  <= '0;
      hpre_q  <= '0;
      fover_q <= 1'b0;
    end else if (i_enable) begin
      state_q <= state_d;
      auto_q  <= auto_d;
      hold_q  <= hold_d;
      hpre_q  <= hpre_d;
      fover_q <= fover_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output select. Short-term holdover follows the manual choice until failover.
  logic [1:0] sel_q, sel_d;
  logic       valid_q, valid_d;

  always_comb begin
    if (mode_q.ref_select_mode == MODE_MANUAL) begin
      sel_d = mode_q.manual_sel;
    end else if (mode_q.ref_select_mode == MODE_SHORT_HOLD) begin
      sel_d = fover_q ? auto_q : mode_q.manual_sel;
    end else begin
      sel_d = auto_q;
    end
    valid_d = state_q != SEL_NONE && state_q != SEL_IDLE;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q   <= '0;
      valid_q <= 1'b0;
    end else if (i_enable) begin
      sel_q   <= sel_d;
      valid_q <= valid_d;
    end
  end

  assign o_ref_select = sel_q;
  assign o_ref_valid  = valid_q;

endmodule // reference_input_selector

// [rtl/ref_select_pkg.sv]
// Constants, field layouts and types for the reference input selector.
// Assumes a single register port on the serial control clock domain.
package ref_select_pkg;

  localparam int          NUM_INPUTS        = 4;
  localparam logic [7:0]  ADDR_PRIORITY     = 8'h14;
  localparam logic [7:0]  ADDR_MODE         = 8'h15;
  localparam logic [7:0]  ADDR_HOLDOFF      = 8'h16;
  localparam logic [7:0]  ADDR_COUNTER      = 8'h17;

  localparam logic [7:0]  RESET_PRIORITY    = 8'hE0;
  localparam logic [7:0]  RESET_MODE        = 8'h00;
  localparam logic [7:0]  RESET_HOLDOFF     = 8'h80;
  localparam logic [7:0]  RESET_COUNTER     = 8'h82;

  localparam logic [7:0]  MASK_MODE         = 8'h7F;
  localparam logic [7:0]  MASK_COUNTER      = 8'hCF;

  localparam logic [1:0]  MODE_MANUAL       = 2'h0;
  localparam logic [1:0]  MODE_AUTO         = 2'h1;
  localparam logic [1:0]  MODE_SHORT_HOLD   = 2'h2;
  localparam logic [1:0]  MODE_AUTO_HOLD    = 2'h3;

  // Validation lengths in counter steps (one input period, or four with the prescale bit), index is the validation count code.
  localparam logic [8:0]  VAL_LEN_DIV1 [4]  = '{9'h002, 9'h010, 9'h020, 9'h040};
  localparam logic [8:0]  VAL_LEN_DIV4 [4]  = '{9'h008, 9'h040, 9'h080, 9'h100};

  // Hold-off prescale exponents, index is the hold-off prescale code.
  localparam logic [4:0]  HOLD_EXP [4]      = '{5'h0F, 5'h10, 5'h11, 5'h11};
  localparam int          HOLD_PRE_W        = 17;

  typedef struct packed {
    logic [1:0] prio_0;
    logic [1:0] prio_1;
    logic [1:0] prio_2;
    logic [1:0] prio_3;
  } priority_s;

  typedef struct packed {
    logic       reserved;
    logic       ref_loss_block;
    logic       validation_prescale_sel;
    logic       revertive_enable;
    logic [1:0] ref_select_mode;
    logic [1:0] manual_sel;
  } mode_s;

  typedef struct packed {
    logic [1:0] holdoff_prescale;
    logic [1:0] reserved;
    logic [1:0] input_powerdown;
    logic [1:0] validation_count;
  } counter_s;

  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_LOCKED,
    SEL_HOLDOFF,
    SEL_NONE
  } sel_state_e;

endpackage

// [test/ref_select_monitor.sv]
// Port checker for the reference input selector.
// Assumes it is bound to the selector and sees its ports only.
`timescale 1ns/10ps
module ref_select_monitor
  import ref_select_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  // Clock, reset and register port.
  input wire logic         i_clock,
  input wire logic         i_reset_n,
  input wire logic         i_enable,
  input wire logic [7:0]   i_reg_addr,
  input wire logic         i_reg_write,
  input wire logic [7:0]   i_reg_wdata,
  input wire logic [7:0]   o_reg_rdata,
  // Reference side.
  input wire logic [N-1:0] i_ref_loss,
  input wire logic [1:0]   o_ref_select,
  input wire logic         o_ref_valid,
  input wire logic [N-1:0] o_loss_flag
);
  mode_s mode_q;
  mode_s mode_d;
  logic  auto;
  always_comb begin
    mode_d = mode_q;
    if (i_enable && i_reg_write && i_reg_addr == ADDR_MODE) begin
      mode_d = i_reg_wdata & MASK_MODE;
    end
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= RESET_MODE;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign auto = mode_q.ref_select_mode[0];
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence hold_write_read;
    i_enable && i_reg_write && i_reg_addr == ADDR_HOLDOFF
      ##1 i_enable && !i_reg_write && i_reg_addr == ADDR_HOLDOFF;
  endsequence
  a_hold_readback: assert property (hold_write_read |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("holdoff readback wrong");
  a_mode_readback: assert property (i_enable && i_reg_addr == ADDR_MODE |=> o_reg_rdata == $past(mode_q))
    else $error("mode readback wrong");
  a_unmapped_zero: assert property (i_enable && !(i_reg_addr inside {[ADDR_PRIORITY:ADDR_COUNTER]})
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_counter_reserved: assert property (i_enable && i_reg_addr == ADDR_COUNTER |=> o_reg_rdata[5:4] == 2'h0)
    else $error("reserved bits not zero");
  a_loss_sets: assert property ((i_enable && i_ref_loss[0])[*5] |-> o_loss_flag[0])
    else $error("loss flag not set");
  a_manual_route: assert property (mode_q.ref_select_mode == MODE_MANUAL && $stable(mode_q) && $past(i_enable)
    |-> o_ref_select == mode_q.manual_sel)
    else $error("manual route wrong");
  a_auto_failover: assert property (auto && $stable(mode_q) && o_ref_valid && o_loss_flag[o_ref_select]
    && !(&o_loss_flag) |-> ##[1:8] !o_loss_flag[o_ref_select])
    else $error("no failover");
  a_revert_off: assert property ((auto && !mode_q.revertive_enable && o_ref_valid && $stable(mode_q)
    && !o_loss_flag[o_ref_select])[*2] |=> $stable(o_ref_select) || o_loss_flag[$past(o_ref_select)])
    else $error("switch without loss");
endmodule // ref_select_monitor

bind reference_input_selector ref_select_monitor #(.N(N)) mon (.i_clock, .i_reset_n, .i_enable, .i_reg_addr,
  .i_reg_write, .i_reg_wdata, .o_reg_rdata, .i_ref_loss, .o_ref_select, .o_ref_valid, .o_loss_flag);

// [test/ref_source_model.sv]
// Model of the redundant reference clock sources.
// Assumes the bench stops a source to stage a loss of signal.
`timescale 1ns/10ps
module ref_source_model #(
  parameter int  N    = 4,
  parameter time HALF = 50ns
) (
  // Per-source stop request.
  input  wire logic [N-1:0] i_stop,
  // Clocks and raw loss levels.
  output logic [N-1:0]      o_ref_clock,
  output logic [N-1:0]      o_ref_loss
);
  logic run_clock = 1'b0;
  always #(HALF) run_clock = ~run_clock;
  // A dead source stands low rather than at a stale level.
  assign o_ref_clock = {N{run_clock}} & ~i_stop;
  assign o_ref_loss  = i_stop;
endmodule // ref_source_model

// [test/tb.sv]
// Self-checking bench for the reference input selector.
// Assumes the source model and the bound checker are compiled first.
`timescale 1ns/10ps
module tb;
  import ref_select_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_s;
  localparam row_s ROWS [11] = '{
    '{1'b0, ADDR_PRIORITY, 8'h00, RESET_PRIORITY}, '{1'b0, ADDR_MODE, 8'h00, RESET_MODE},
    '{1'b0, ADDR_HOLDOFF, 8'h00, RESET_HOLDOFF}, '{1'b0, ADDR_COUNTER, 8'h00, RESET_COUNTER},
    '{1'b1, ADDR_PRIORITY, 8'h5A, 8'h5A}, '{1'b1, ADDR_MODE, 8'hFF, 8'h7F},
    '{1'b1, ADDR_HOLDOFF, 8'h00, 8'h00}, '{1'b1, ADDR_COUNTER, 8'hFF, 8'hCF},
    '{1'b1, 8'h20, 8'hAA, 8'h00}, '{1'b1, ADDR_COUNTER, 8'h00, 8'h00}, '{1'b1, ADDR_MODE, 8'h00, 8'h00}};
  logic       clock     = 1'b0;
  logic       reset_n   = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic       reg_write = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] stop      = 4'h0;
  logic       en        = 1'b1;
  logic [7:0] rdata;
  logic [3:0] ref_clock;
  logic [3:0] ref_loss;
  logic [1:0] sel;
  logic       valid;
  logic [3:0] loss;
  logic [7:0] v;
  int         err_total    = 0;
  int         total_checks = 0;
  always #12.5 clock = ~clock;
  ref_source_model SRC (.i_stop(stop), .o_ref_clock(ref_clock), .o_ref_loss(ref_loss));
  reference_input_selector DUT (.i_clock(clock), .i_reset_n(reset_n), .i_enable(en), .i_reg_addr(reg_addr),
    .i_reg_write(reg_write), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .i_ref_clock(ref_clock),
    .i_ref_loss(ref_loss), .o_ref_select(sel), .o_ref_valid(valid), .o_loss_flag(loss));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_write = 1'b1;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    r = rdata;
  endtask
  // Sets the dead sources, waits, then returns the selection for checking.
  task automatic go(input logic [3:0] s, input int w, output logic [7:0] r);
    @(negedge clock);
    stop = s;
    repeat (w) @(negedge clock);
    r = {6'h00, sel};
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].data);
      rd(ROWS[i].addr, v);
      chk(v, ROWS[i].exp);
    end
    $display("register table done");
    wr(ADDR_MODE, 8'h01);
    go(4'h0, 4, v); chk(v, 8'h01);
    wr(ADDR_MODE, 8'h19);
    go(4'h0, 4, v); chk(v, 8'h01);
    wr(ADDR_MODE, 8'h00);
    go(4'h0, 4, v); chk(v, 8'h00);
    $display("manual modes done");
    wr(ADDR_PRIORITY, 8'h1B);
    wr(ADDR_MODE, 8'h04);
    go(4'h1, 20, v); chk(v, 8'h03);
    chk({4'h0, loss}, 8'h01);
    chk({7'h00, valid}, 8'h01);
    go(4'h9, 20, v); chk(v, 8'h02);
    chk({4'h0, loss}, 8'h09);
    go(4'h1, 40, v); chk(v, 8'h02);
    go(4'h0, 40, v); chk(v, 8'h02);
    chk({4'h0, loss}, 8'h00);
    wr(ADDR_PRIORITY, 8'hF0);
    go(4'h4, 20, v); chk(v, 8'h00);
    $display("automatic mode done");
    // Input 2 revalidates while outranking the current reference.
    wr(ADDR_MODE, 8'h14);
    wr(ADDR_PRIORITY, 8'h0C);
    go(4'h0, 40, v); chk(v, 8'h02);
    wr(ADDR_PRIORITY, 8'hC0);
    go(4'h2, 20, v); chk(v, 8'h02);
    go(4'h0, 40, v); chk(v, 8'h02);
    $display("revertive mode done");
    // Short-term holdover keeps the manual input until the hold-off runs out.
    wr(ADDR_MODE, 8'h08);
    go(4'h1, 20, v); chk(v, 8'h00);
    chk({7'h00, valid}, 8'h01);
    go(4'h1, 32800, v); chk(v, 8'h01);
    wr(ADDR_MODE, 8'h0C);
    go(4'h0, 40, v); chk(v, 8'h01);
    chk({4'h0, loss}, 8'h00);
    $display("holdover modes done");
    en = 1'b0;
    wr(ADDR_MODE, 8'h01);
    en = 1'b1;
    rd(ADDR_MODE, v); chk(v, 8'h0C);
    @(negedge clock);
    reset_n = 1'b0;
    @(negedge clock);
    chk({1'b0, valid, sel, loss}, 8'h00);
    reset_n = 1'b1;
    rd(ADDR_MODE, v); chk(v, RESET_MODE);
    chk({7'h00, valid}, 8'h01);
    $display("freeze and reset done");
    summarize();
  end
endmodule // tb
